/* File: fpss_save_restore.sv */
// fpss_save_restore: sequencer that writes and reads memory images of
// the float environment, data registers and media registers.
// assumes a zero-wait apb master and a memory that acks each word.
//
// The implementer's own choices: the register addresses and the APB interface to the registers.
module fpss_save_restore #(
	parameter logic SAVE_SUPPORTED = 1'b1
) (
	// clock and reset
	input  wire logic        clk,
	input  wire logic        rst_n,
	// apb slave
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	// memory port
	output logic             memReq,
	output logic             memWe,
	output logic      [31:0] memAddr,
	output logic      [31:0] memWdata,
	output logic      [3:0]  memBe,
	input  wire logic [31:0] memRdata,
	input  wire logic        memAck,
	// core side
	output logic             excReq,
	input  wire logic        excAck,
	input  wire logic        noteValid,
	input  wire logic [7:0]  noteOpByte1,
	input  wire logic [7:0]  noteOpByte2,
	input  wire logic [63:0] noteIp,
	input  wire logic [15:0] noteCs,
	input  wire logic [63:0] noteDp,
	input  wire logic [15:0] noteDs,
	// identification flags
	output logic             idSaveSupported,
	output logic             idOsEnabled
);

	localparam int RW = fpss_pkg::REG_W;
	localparam int MW = fpss_pkg::MED_W;
	localparam int IB = fpss_pkg::IMG_B;

	// whole state of the block
	typedef struct packed {
		fpss_pkg::fpss_fsm_t  fsm;
		fpss_pkg::fpss_op_t   op;
		fpss_pkg::fpss_mode_t mode;
		logic [6:0]           idx;    // current word
		logic [6:0]           cnt;    // words in image
		logic [31:0]          base;
		logic [31:0]          addr;
		logic [31:0]          wd;     // outgoing word
		logic [3:0]           be;
		logic                 we;
		logic                 done;
		logic [31:0]          rdat;
		logic                 perr;
		logic                 osEn;
		logic [3:0]           esel;
		logic [15:0]          float_control_word;
		logic [15:0]          float_status_word;
		logic [15:0]          float_tag_word;
		logic [10:0]          opc;
		logic [63:0]          ip;
		logic [63:0]          dp;
		logic [15:0]          cs;
		logic [15:0]          ds;
		logic [31:0]          mxcsr;
		logic [7:0][RW-1:0]   fpr;
		logic [7:0][MW-1:0]   xmm;
		logic [IB-1:0]        img;
	} fpss_st_t;

	fpss_st_t st_q; // registered state
	fpss_st_t st_d; // next state

	default clocking @(posedge clk);
	endclocking
	default disable iff (!rst_n);

	////////////////////////////////////////////////////////////////
	// image helpers

	// 16-bit legacy layouts use halfword packing
	function automatic logic is16(input fpss_pkg::fpss_mode_t m);
		return m == fpss_pkg::M_PROT16 || m == fpss_pkg::M_REAL16;
	endfunction : is16

	function automatic logic isSave(input fpss_pkg::fpss_op_t o);
		return o == fpss_pkg::OP_CHK_SAVE || o == fpss_pkg::OP_UNCHK_SAVE
			|| o == fpss_pkg::OP_ENV_STORE || o == fpss_pkg::OP_EXT_SAVE;
	endfunction : isSave

	function automatic logic isEnv(input fpss_pkg::fpss_op_t o);
		return o == fpss_pkg::OP_ENV_STORE || o == fpss_pkg::OP_ENV_LOAD
			|| o == fpss_pkg::OP_ENV_LOADU;
	endfunction : isEnv

	function automatic logic isExt(input fpss_pkg::fpss_op_t o);
		return o == fpss_pkg::OP_EXT_SAVE || o == fpss_pkg::OP_EXT_RST;
	endfunction : isExt

	// environment ops stop at the environment: same head as full image
	function automatic logic [6:0] words(input fpss_pkg::fpss_op_t o, input fpss_pkg::fpss_mode_t m);
		if (isExt(o))
			return fpss_pkg::N_EXT;
		if (isEnv(o))
			return is16(m) ? fpss_pkg::N_ENV16 : fpss_pkg::N_ENV32;
		return is16(m) ? fpss_pkg::N_LEG16 : fpss_pkg::N_LEG32;
	endfunction : words

	// 16-bit images end on a halfword
	function automatic logic [3:0] lastBe(input fpss_pkg::fpss_op_t o, input fpss_pkg::fpss_mode_t m);
		return (is16(m) && !isExt(o)) ? fpss_pkg::BE_LOW : fpss_pkg::BE_FULL;
	endfunction : lastBe

	// build the memory image from live state
	function automatic logic [IB-1:0] packImg(input fpss_st_t s);
		logic [fpss_pkg::NREG*RW-1:0] stk;
		logic [IB-1:0]                v;
		logic [2:0]                   top;
		logic                         es;
		logic [63:0]                  ipw;
		logic [63:0]                  dpw;
		v   = '0;
		top = s.float_status_word[fpss_pkg::TOP_HI:fpss_pkg::TOP_LO];
		es  = s.float_status_word[fpss_pkg::ES_BIT];
		for (int i = 0; i < fpss_pkg::NREG; i++)
			stk[i*RW +: RW] = s.fpr[3'(top + 3'(i))];
		// long mode with wide operands keeps flat pointers
		ipw = (s.mode == fpss_pkg::M_LONG64) ? s.ip : {16'h0000, s.cs, s.ip[31:0]};
		dpw = (s.mode == fpss_pkg::M_LONG64) ? s.dp : {16'h0000, s.ds, s.dp[31:0]};
		if (isExt(s.op))
		begin
			v[63:0]    = {5'h00, es ? s.opc : 11'h000, s.float_tag_word, s.float_status_word, s.float_control_word};
			v[127:64]  = es ? ipw : 64'h0000_0000_0000_0000;
			v[191:128] = es ? dpw : 64'h0000_0000_0000_0000;
			v[223:192] = s.mxcsr;
			for (int i = 0; i < fpss_pkg::NREG; i++)
			begin
				v[fpss_pkg::X_FPR + i*MW +: RW] = stk[i*RW +: RW];
				v[fpss_pkg::X_MED + i*MW +: MW] = s.xmm[i];
			end
		end
		else if (s.mode == fpss_pkg::M_REAL16)
			v[fpss_pkg::ENV16_B+RW*fpss_pkg::NREG-1:0] = {stk, s.dp[19:16], 12'h000,
				s.dp[15:0], s.ip[19:16], 1'b0, s.opc, s.ip[15:0], s.float_tag_word, s.float_status_word, s.float_control_word};
		else if (s.mode == fpss_pkg::M_PROT16)
			v[fpss_pkg::ENV16_B+RW*fpss_pkg::NREG-1:0] = {stk, s.ds, s.dp[15:0],
				s.cs, s.ip[15:0], s.float_tag_word, s.float_status_word, s.float_control_word};
		else
			v[fpss_pkg::ENV32_B+RW*fpss_pkg::NREG-1:0] = {stk, 16'h0000, s.ds, s.dp[31:0],
				5'h00, s.opc, s.cs, s.ip[31:0], 16'h0000, s.float_tag_word, 16'h0000, s.float_status_word, 16'h0000, s.float_control_word};
		return v;
	endfunction : packImg

	// reload state from the buffer in the layout the save wrote
	function automatic fpss_st_t unpackImg(input fpss_st_t s);
		fpss_st_t                     r;
		logic [IB-1:0]                v;
		logic [fpss_pkg::NREG*RW-1:0] stk;
		logic [2:0]                   top;
		r   = s;
		v   = s.img;
		stk = '0;
		if (isExt(s.op))
		begin
			{r.float_tag_word, r.float_status_word, r.float_control_word} = v[47:0];
			r.mxcsr = v[223:192];
			if (r.float_status_word[fpss_pkg::ES_BIT])
			begin
				r.opc = v[58:48];
				if (s.mode == fpss_pkg::M_LONG64)
					{r.dp, r.ip} = v[191:64];
				else
				begin
					{r.cs, r.ip} = {v[111:96], 32'h0000_0000, v[95:64]};
					{r.ds, r.dp} = {v[175:160], 32'h0000_0000, v[159:128]};
				end
			end
			for (int i = 0; i < fpss_pkg::NREG; i++)
			begin
				stk[i*RW +: RW] = v[fpss_pkg::X_FPR + i*MW +: RW];
				r.xmm[i]        = v[fpss_pkg::X_MED + i*MW +: MW];
			end
		end
		else if (is16(s.mode))
		begin
			{r.float_tag_word, r.float_status_word, r.float_control_word} = v[47:0];
			stk = v[fpss_pkg::ENV16_B +: RW*fpss_pkg::NREG];
			if (s.mode == fpss_pkg::M_REAL16)
			begin
				r.ip  = {44'h000_0000_0000, v[79:76], v[63:48]};
				r.opc = v[74:64];
				r.dp  = {44'h000_0000_0000, v[111:108], v[95:80]};
			end
			else
			begin
				r.ip = {48'h0000_0000_0000, v[63:48]};
				r.cs = v[79:64];
				r.dp = {48'h0000_0000_0000, v[95:80]};
				r.ds = v[111:96];
			end
		end
		else
		begin
			{r.float_status_word, r.float_control_word} = {v[47:32], v[15:0]};
			r.float_tag_word = v[79:64];
			r.ip  = {32'h0000_0000, v[127:96]};
			{r.opc, r.cs} = v[154:128];
			r.dp  = {32'h0000_0000, v[191:160]};
			r.ds  = v[207:192];
			stk   = v[fpss_pkg::ENV32_B +: RW*fpss_pkg::NREG];
		end
		// data registers back to physical slots, from the new pile top
		top = r.float_status_word[fpss_pkg::TOP_HI:fpss_pkg::TOP_LO];
		if (!isEnv(s.op))
			for (int i = 0; i < fpss_pkg::NREG; i++)
				r.fpr[3'(top + 3'(i))] = stk[i*RW +: RW];
		return r;
	endfunction : unpackImg

	////////////////////////////////////////////////////////////////
	// next-state logic
	logic pending; // unmasked exception waiting
	logic hit;     // apb address decodes
	logic [31:0] rd; // read mux

	always_comb
	begin
		st_d    = st_q;
		pending = |(st_q.float_status_word[fpss_pkg::EXC_W-1:0] & ~st_q.float_control_word[fpss_pkg::EXC_W-1:0]);
		hit     = 1'b1;
		rd      = 32'h0000_0000;
		// read mux, registered in the setup phase
		case (paddr)
			fpss_pkg::A_CTRL: rd = {25'h000_0000, st_q.mode, 1'b0, st_q.op};
			fpss_pkg::A_STAT: rd = {29'h0000_0000, st_q.fsm != fpss_pkg::S_IDLE,
				st_q.fsm == fpss_pkg::S_EXC, st_q.done};
			fpss_pkg::A_BASE: rd = st_q.base;
			fpss_pkg::A_FEAT: rd = {30'h0000_0000, SAVE_SUPPORTED, st_q.osEn};
			fpss_pkg::A_ESEL: rd = {28'h000_0000, st_q.esel};
			// sub-leaf 0 sums, sub-leaves 1 and 2 describe one component each, higher ones read zero
			fpss_pkg::A_EOFF: rd = (st_q.esel == 4'h2) ? fpss_pkg::SZ_FLOAT : 32'h0000_0000;
			fpss_pkg::A_ESIZ: rd = (st_q.esel == 4'h0) ? fpss_pkg::SZ_TOTAL :
				(st_q.esel == 4'h1) ? fpss_pkg::SZ_FLOAT :
				(st_q.esel == 4'h2) ? fpss_pkg::SZ_MEDIA : 32'h0000_0000;
			fpss_pkg::A_ENV0: rd = {st_q.float_status_word, st_q.float_control_word};
			fpss_pkg::A_ENV1: rd = {16'h0000, st_q.float_tag_word};
			fpss_pkg::A_MXCS: rd = st_q.mxcsr;
			default:          hit = 1'b0;
		endcase
		if (psel && !penable)
		begin
			st_d.rdat = rd;
			st_d.perr = !hit;
		end
		// writes; state registers only change while idle
		if (psel && penable && pwrite && !st_q.perr && st_q.fsm == fpss_pkg::S_IDLE)
			case (paddr)
				fpss_pkg::A_CTRL:
				begin
					st_d.op   = fpss_pkg::fpss_op_t'(pwdata[2:0]);
					st_d.mode = (pwdata[6:4] > 3'(fpss_pkg::M_LONG32)) ? fpss_pkg::M_PROT32
						: fpss_pkg::fpss_mode_t'(pwdata[6:4]);
					st_d.cnt  = words(st_d.op, st_d.mode);
					st_d.we   = isSave(st_d.op);
					st_d.idx  = 7'h00;
					st_d.addr = st_q.base;
					st_d.be   = fpss_pkg::BE_FULL;
					st_d.done = 1'b0;
					// only checked ops stop for a pending exception
					if (pending && (st_d.op == fpss_pkg::OP_CHK_SAVE
						|| st_d.op == fpss_pkg::OP_ENV_STORE || st_d.op == fpss_pkg::OP_ENV_LOAD))
						st_d.fsm = fpss_pkg::S_EXC;
					else
						st_d.fsm = st_d.we ? fpss_pkg::S_PACK : fpss_pkg::S_XFER;
				end
				fpss_pkg::A_BASE: st_d.base = pwdata;
				fpss_pkg::A_FEAT: st_d.osEn = pwdata[0];
				fpss_pkg::A_ESEL: st_d.esel = pwdata[3:0];
				fpss_pkg::A_ENV0: {st_d.float_status_word, st_d.float_control_word} = pwdata;
				fpss_pkg::A_ENV1: st_d.float_tag_word = pwdata[15:0];
				fpss_pkg::A_MXCS: st_d.mxcsr = pwdata;
				default: ;
			endcase
		// core reports last instruction while idle
		if (noteValid && st_q.fsm == fpss_pkg::S_IDLE)
		begin
			st_d.opc = {noteOpByte1[2:0], noteOpByte2};
			st_d.ip  = noteIp;
			st_d.cs  = noteCs;
			st_d.dp  = noteDp;
			st_d.ds  = noteDs;
		end
		// sequencer
		case (st_q.fsm)
			fpss_pkg::S_IDLE: ;
			// the handler runs in the core; the save or load starts after excAck
			fpss_pkg::S_EXC:
				if (excAck)
					st_d.fsm = st_q.we ? fpss_pkg::S_PACK : fpss_pkg::S_XFER;
			fpss_pkg::S_PACK:
			begin
				st_d.img = packImg(st_q);
				st_d.wd  = st_d.img[31:0];
				st_d.fsm = fpss_pkg::S_XFER;
			end
			fpss_pkg::S_XFER:
				if (memAck)
				begin
					if (!st_q.we)
						st_d.img[st_q.idx*32 +: 32] = memRdata;
					if (st_q.idx == st_q.cnt - 7'h01)
					begin
						st_d.fsm = st_q.we ? fpss_pkg::S_IDLE : fpss_pkg::S_UNPK;
						st_d.done = st_q.we;
						// legacy save frees every register; extended save keeps tags
						if (st_q.op == fpss_pkg::OP_CHK_SAVE || st_q.op == fpss_pkg::OP_UNCHK_SAVE)
							st_d.float_tag_word = fpss_pkg::TAG_EMPTY;
					end
					else
					begin
						st_d.idx  = st_q.idx + 7'h01;
						st_d.addr = st_q.addr + fpss_pkg::WORD_BYTES;
						st_d.wd   = st_q.img[(st_q.idx + 7'h01)*32 +: 32];
						st_d.be   = (st_q.idx + 7'h02 == st_q.cnt) ? lastBe(st_q.op, st_q.mode)
							: fpss_pkg::BE_FULL;
					end
				end
			fpss_pkg::S_UNPK:
			begin
				st_d      = unpackImg(st_q);
				st_d.fsm  = fpss_pkg::S_IDLE;
				st_d.done = 1'b1;
			end
			default: st_d.fsm = fpss_pkg::S_IDLE;
		endcase
	end

	// state register, synchronous reset
	always_ff @(posedge clk)
	begin
		if (!rst_n)
			st_q <= '0;
		else
			st_q <= st_d;
	end

	////////////////////////////////////////////////////////////////
	// outputs
	assign prdata          = st_q.rdat;
	assign pready          = 1'b1;
	assign pslverr         = psel && penable && st_q.perr;
	assign memReq          = st_q.fsm == fpss_pkg::S_XFER;
	assign memWe           = st_q.we;
	assign memAddr         = st_q.addr;
	assign memWdata        = st_q.wd;
	assign memBe           = st_q.be;
	assign excReq          = st_q.fsm == fpss_pkg::S_EXC;
	assign idSaveSupported = SAVE_SUPPORTED;
	assign idOsEnabled     = st_q.osEn;

	////////////////////////////////////////////////////////////////
	// checks
	exc_before_mem_a: assert property (!(excReq && memReq))
		else $error("memory access during exception wait");
	unchk_no_exc_a: assert property ((st_q.fsm == fpss_pkg::S_IDLE && st_d.fsm != fpss_pkg::S_IDLE
		&& (st_d.op == fpss_pkg::OP_UNCHK_SAVE || st_d.op == fpss_pkg::OP_EXT_SAVE)) |=> !excReq)
		else $error("unchecked save waited for exception");
	tag_empty_a: assert property ((memAck && memReq && memWe && st_q.idx == st_q.cnt - 7'h01
		&& st_q.op == fpss_pkg::OP_CHK_SAVE) |=> st_q.float_tag_word == fpss_pkg::TAG_EMPTY)
		else $error("tags not emptied after save");
	ext_tag_keep_a: assert property ((st_q.op == fpss_pkg::OP_EXT_SAVE
		&& st_q.fsm != fpss_pkg::S_IDLE) |=> $stable(st_q.float_tag_word))
		else $error("extended save changed tags");
	env_len_a: assert property ((memReq && isEnv(st_q.op)) |-> st_q.idx < fpss_pkg::N_ENV32)
		else $error("environment op went past environment");
	ext_ptr_zero_a: assert property ((memReq && st_q.op == fpss_pkg::OP_EXT_SAVE
		&& !st_q.float_status_word[fpss_pkg::ES_BIT] && st_q.idx == 7'h02) |-> memWdata == 32'h0000_0000)
		else $error("pointer written without summary bit");
	opc_form_a: assert property ((noteValid && st_q.fsm == fpss_pkg::S_IDLE)
		|=> st_q.opc == {$past(noteOpByte1[2:0]), $past(noteOpByte2)})
		else $error("opcode field malformed");
	req_hold_a: assert property ((memReq && !memAck) |=> memReq && $stable(memAddr))
		else $error("memory request dropped before ack");
	os_flag_a: assert property ((psel && penable && pwrite && paddr == fpss_pkg::A_FEAT
		&& !st_q.perr && st_q.fsm == fpss_pkg::S_IDLE) |=> idOsEnabled == $past(pwdata[0]))
		else $error("os enable flag not reported");

endmodule : fpss_save_restore

/* File: fpss_pkg.sv */
// fpss_pkg: constants, register map and enumerations of the
// floating-point / media state save and restore sequencer.
// assumes an apb register port and a word-wide memory port.
package fpss_pkg;

	////////////////////////////////////////////////////////////////
	// apb register offsets (byte addresses)
	localparam logic [7:0] A_CTRL = 8'h00; // op start
	localparam logic [7:0] A_STAT = 8'h04; // busy, waiting, done
	localparam logic [7:0] A_BASE = 8'h08; // image base address
	localparam logic [7:0] A_FEAT = 8'h0C; // identification flags
	localparam logic [7:0] A_ESEL = 8'h10; // enumeration sub-leaf
	localparam logic [7:0] A_EOFF = 8'h14; // component offset
	localparam logic [7:0] A_ESIZ = 8'h18; // component size
	localparam logic [7:0] A_ENV0 = 8'h1C; // status:control word
	localparam logic [7:0] A_ENV1 = 8'h20; // tag word
	localparam logic [7:0] A_MXCS = 8'h24; // media control/status

	////////////////////////////////////////////////////////////////
	// field positions
	localparam int ES_BIT = 7;  // exception summary in status word
	localparam int TOP_HI = 13; // pile top field
	localparam int TOP_LO = 11;
	localparam int EXC_W  = 6;  // exception flags / masks
	localparam int REG_W  = 80; // physical float register
	localparam int MED_W  = 128; // media register
	localparam int NREG   = 8;
	localparam int ENV32_B = 224; // 28-byte environment
	localparam int ENV16_B = 112; // 14-byte environment
	localparam int X_FPR  = 256;  // extended image float area (bits)
	localparam int X_MED  = 1280; // extended image media area (bits)
	localparam int IMG_W  = 72;   // buffer words
	localparam int IMG_B  = IMG_W * 32;

	////////////////////////////////////////////////////////////////
	// word counts, strobes, values
	localparam logic [6:0] N_LEG32 = 7'h1B;
	localparam logic [6:0] N_ENV32 = 7'h07;
	localparam logic [6:0] N_LEG16 = 7'h18;
	localparam logic [6:0] N_ENV16 = 7'h04;
	localparam logic [6:0] N_EXT   = 7'h48;
	localparam logic [3:0] BE_FULL = 4'hF;
	localparam logic [3:0] BE_LOW  = 4'h3;
	localparam logic [15:0] TAG_EMPTY = 16'hFFFF;
	localparam logic [31:0] WORD_BYTES = 32'h0000_0004;
	localparam logic [31:0] SZ_TOTAL = 32'h0000_0120; // 288 bytes
	localparam logic [31:0] SZ_FLOAT = 32'h0000_00A0; // 160 bytes
	localparam logic [31:0] SZ_MEDIA = 32'h0000_0080; // 128 bytes

	////////////////////////////////////////////////////////////////
	// enumerations
	typedef enum logic [2:0] {
		OP_CHK_SAVE = 3'b000, OP_UNCHK_SAVE = 3'b001, OP_FULL_RST = 3'b010,
		OP_ENV_STORE = 3'b011, OP_ENV_LOAD = 3'b100, OP_ENV_LOADU = 3'b101,
		OP_EXT_SAVE = 3'b110, OP_EXT_RST = 3'b111
	} fpss_op_t;
	typedef enum logic [2:0] {
		M_PROT32 = 3'b000, M_REAL32 = 3'b001, M_PROT16 = 3'b010,
		M_REAL16 = 3'b011, M_LONG64 = 3'b100, M_LONG32 = 3'b101
	} fpss_mode_t;
	typedef enum logic [2:0] {
		S_IDLE = 3'b000, S_EXC = 3'b001, S_PACK = 3'b010,
		S_XFER = 3'b011, S_UNPK = 3'b100
	} fpss_fsm_t;

endpackage : fpss_pkg

/* File: fpss_mem_model.sv */
// fpss_mem_model: system memory holding the save image, one word per ack.
// assumes memReq, address, data and strobes stand until the ack pulse.
module fpss_mem_model (
	// clock and pace
	input  wire logic        clk,
	input  wire logic        slow,
	// memory port
	input  wire logic        memReq,
	input  wire logic        memWe,
	input  wire logic [31:0] memAddr,
	input  wire logic [31:0] memWdata,
	input  wire logic [3:0]  memBe,
	output logic      [31:0] memRdata,
	output logic             memAck
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [31:0] mem [1024]; // image store, marker filled
	logic [31:0] rdQ;        // word of the last read
	int          waitQ;      // cycles waited on this word
	initial
	begin
		for (int i = 0; i < 1024; i++)
			mem[i] = {16'hC0DE, 16'(i)};
		memAck = 1'b0;
		rdQ = '0;
		waitQ = 0;
	end
	// data scrambled outside the ack cycle so nothing stale passes
	assign memRdata = memAck ? rdQ : ~rdQ;
	////////////////////////////////////////////////////////////////
	// ack after 0 or 6 wait cycles, write only the enabled bytes
	always @(posedge clk)
	begin
		memAck <= 1'b0;
		if (memReq && memAck)
		begin
			waitQ <= 0;
			if (memWe)
				for (int b = 0; b < 4; b++)
					if (memBe[b])
						mem[memAddr[11:2]][8*b+:8] <= memWdata[8*b+:8];
		end
		else if (memReq)
		begin
			if (waitQ >= (slow ? 6 : 0))
			begin
				memAck <= 1'b1;
				rdQ <= mem[memAddr[11:2]];
			end
			else
				waitQ <= waitQ + 1;
		end
	end
endmodule : fpss_mem_model

/* File: tb_top.sv */
// tb_top: apb driven sequences of saves, restores and identification reads.
// assumes the memory model acks every word and a core stand-in acks exceptions.
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	`define CHK(nm, exp, got) begin n_compared++; if ((got) !== (exp)) begin error_cnt++; \
		$display("BAD %s exp %h got %h", nm, exp, got); end end
	`define MW mem_model_inst.mem
	// apb, memory and core side nets
	logic        clk, rst_n, psel, penable, pwrite, pready, pslverr;
	logic [7:0]  paddr, noteOpByte1, noteOpByte2;
	logic [31:0] pwdata, prdata, memAddr, memWdata, memRdata, rd;
	logic        memReq, memWe, memAck, slow, excReq, excAck, noteValid, err;
	logic [3:0]  memBe;
	logic [63:0] noteIp, noteDp;
	logic [15:0] noteCs, noteDs;
	logic        idSaveSupported, idOsEnabled;
	int          error_cnt, n_compared, cycles, excSeen, memInExc, e0;
	// expected enumeration answers per sub-leaf
	localparam logic [31:0] OFF_X [3] = '{32'h0, 32'h0, fpss_pkg::SZ_FLOAT};
	localparam logic [31:0] SIZ_X [3] = '{fpss_pkg::SZ_TOTAL, fpss_pkg::SZ_FLOAT, fpss_pkg::SZ_MEDIA};
	// legacy 32-bit image: pending flag 0 unmasked, pile top 7
	localparam logic [31:0] ENV_X [7] = '{32'h0000_037E, 32'h0000_3801, 32'h0000_5555,
		32'h1234_5678, 32'h01F8_0023, 32'h9ABC_DEF0, 32'h0000_002B};
	fpss_save_restore fpss_save_restore_inst (.clk, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata,
		.prdata, .pready, .pslverr, .memReq, .memWe, .memAddr, .memWdata, .memBe, .memRdata, .memAck,
		.excReq, .excAck, .noteValid, .noteOpByte1, .noteOpByte2, .noteIp, .noteCs, .noteDp, .noteDs,
		.idSaveSupported, .idOsEnabled);
	fpss_mem_model mem_model_inst (.clk, .slow, .memReq, .memWe, .memAddr, .memWdata, .memBe,
		.memRdata, .memAck);
	initial
	begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end
	////////////////////////////////////////////////////////////////
	// core stand-in acks an exception on the next cycle count divisible by three; hang guard
	always @(posedge clk)
	begin
		cycles++;
		excAck <= excReq && !excAck && cycles % 3 == 0;
		if (excReq && !excAck && cycles % 3 == 0)
			excSeen <= excSeen + 1;
		if (excReq && memReq)
			memInExc <= memInExc + 1;
		if (cycles == 20000)
		begin
			error_cnt++;
			report_and_stop();
		end
	end
	// one apb transfer; read data and error taken at the pready edge
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		do @(posedge clk); while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	// start one operation and poll status until done and idle
	task automatic run(input logic [2:0] op, input logic [2:0] mode, input logic [31:0] base);
		int n;
		apb(1'b1, fpss_pkg::A_BASE, base);
		apb(1'b1, fpss_pkg::A_CTRL, {25'h0, mode, 1'b0, op});
		n = 0;
		do
		begin
			apb(1'b0, fpss_pkg::A_STAT, 32'h0);
			n++;
		end
		while (rd[2:0] !== 3'b001 && n < 400);
		`CHK("done", 3'b001, rd[2:0])
	endtask : run
	task automatic report_and_stop();
		$display("compared %0d mismatches %0d", n_compared, error_cnt);
		if (error_cnt == 0 && n_compared > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : report_and_stop
	////////////////////////////////////////////////////////////////
	// main sequence
	initial
	begin
		{rst_n, psel, penable, pwrite, paddr, pwdata, slow, excAck, noteValid} = '0;
		{noteOpByte1, noteOpByte2, noteIp, noteCs, noteDp, noteDs} = '0;
		{error_cnt, n_compared, cycles, excSeen, memInExc} = '0;
		repeat (10) @(posedge clk);
		rst_n <= 1'b1;
		apb(1'b0, fpss_pkg::A_STAT, 32'h0);
		`CHK("stat", 32'h0, rd)
		apb(1'b0, fpss_pkg::A_FEAT, 32'h0);
		`CHK("feat", 32'h2, rd)
		apb(1'b1, fpss_pkg::A_FEAT, 32'h1);
		// the flag flop updates at the access edge itself; look once it has settled
		@(negedge clk);
		`CHK("osen", 1'b1, idOsEnabled)
		`CHK("supp", 1'b1, idSaveSupported)
		apb(1'b0, 8'h40, 32'h0);
		`CHK("unmapped", 1'b1, err)
		for (int i = 0; i < 3; i++)
		begin
			apb(1'b1, fpss_pkg::A_ESEL, i);
			apb(1'b0, fpss_pkg::A_EOFF, 32'h0);
			`CHK("eoff", OFF_X[i], rd)
			apb(1'b0, fpss_pkg::A_ESIZ, 32'h0);
			`CHK("esiz", SIZ_X[i], rd)
		end
		$display("test ident done");
		// legacy restore, then unchecked and checked saves of it
		for (int i = 0; i < 27; i++)
			`MW[i] = (i < 7) ? ENV_X[i] : 32'hA5A5_0000 + 32'(i);
		run(fpss_pkg::OP_FULL_RST, fpss_pkg::M_PROT32, 32'h0);
		apb(1'b0, fpss_pkg::A_ENV0, 32'h0);
		`CHK("env0", 32'h3801_037E, rd)
		e0 = excSeen;
		run(fpss_pkg::OP_UNCHK_SAVE, fpss_pkg::M_PROT32, 32'h400);
		`CHK("noexc", e0, excSeen)
		for (int i = 0; i < 27; i++)
			`CHK("image", `MW[i], `MW[256+i])
		`CHK("mediaskip", {16'hC0DE, 16'd283}, `MW[283])
		apb(1'b0, fpss_pkg::A_ENV1, 32'h0);
		`CHK("tagempty", 32'h0000_FFFF, rd)
		run(fpss_pkg::OP_CHK_SAVE, fpss_pkg::M_PROT32, 32'h400);
		`CHK("excfirst", e0 + 1, excSeen)
		`CHK("memquiet", 0, memInExc)
		$display("test legacy done");
		// note a last instruction, then environment stores in M_PROT32, M_REAL16 and M_PROT16
		@(posedge clk);
		noteValid <= 1'b1;
		{noteOpByte1, noteOpByte2, noteCs, noteDs} <= {8'hD9, 8'hF8, 16'h0023, 16'h002B};
		{noteIp, noteDp} <= {64'h000A_1234, 64'h0005_6788};
		@(posedge clk);
		noteValid <= 1'b0;
		run(fpss_pkg::OP_ENV_STORE, fpss_pkg::M_PROT32, 32'h800);
		`CHK("ip32", 32'h000A_1234, `MW[515])
		`CHK("opcs32", 32'h01F8_0023, `MW[516])
		`CHK("dp32", 32'h0005_6788, `MW[517])
		`CHK("envonly", {16'hC0DE, 16'd519}, `MW[519])
		run(fpss_pkg::OP_ENV_STORE, fpss_pkg::M_REAL16, 32'hA00);
		`CHK("real16w2", 32'h6788_A1F8, `MW[642])
		`CHK("real16w3", 32'hC0DE_5000, `MW[643])
		`CHK("real16end", {16'hC0DE, 16'd644}, `MW[644])
		run(fpss_pkg::OP_ENV_STORE, fpss_pkg::M_PROT16, 32'hB00);
		`CHK("prot16w1", 32'h1234_FFFF, `MW[705])
		`CHK("prot16w3", 32'hC0DE_002B, `MW[707])
		$display("test env done");
		// extended image, slow memory, summary clear then set
		slow <= 1'b1;
		apb(1'b1, fpss_pkg::A_ENV1, 32'h0000_1234);
		e0 = excSeen;
		run(fpss_pkg::OP_EXT_SAVE, fpss_pkg::M_LONG32, 32'hC00);
		`CHK("noptr", 32'h0, `MW[770] | `MW[773])
		`CHK("extend", {16'hC0DE, 16'd840}, `MW[840])
		`CHK("extnoexc", e0, excSeen)
		apb(1'b0, fpss_pkg::A_ENV1, 32'h0);
		`CHK("tagkept", 32'h0000_1234, rd)
		apb(1'b1, fpss_pkg::A_ENV0, 32'h3881_037E);
		run(fpss_pkg::OP_EXT_SAVE, fpss_pkg::M_LONG32, 32'hE00);
		`CHK("xop", 32'h01F8_1234, `MW[897])
		`CHK("xipsel", 32'h0000_0023, `MW[899])
		`CHK("xdp", 32'h0005_6788, `MW[900])
		`CHK("xdsel", 32'h0000_002B, `MW[901])
		run(fpss_pkg::OP_EXT_RST, fpss_pkg::M_LONG32, 32'hC00);
		apb(1'b0, fpss_pkg::A_ENV0, 32'h0);
		`CHK("xrestore", 32'h3801_037E, rd)
		// wide long mode keeps flat pointers: upper halves are pointer bits, not selectors
		apb(1'b1, fpss_pkg::A_ENV0, 32'h3881_037E);
		run(fpss_pkg::OP_EXT_SAVE, fpss_pkg::M_LONG64, 32'h0);
		`CHK("flatip", 32'h0, `MW[3])
		`CHK("flatdp", 32'h0, `MW[5])
		$display("test extended done");
		report_and_stop();
	end
endmodule : tb_top
